// ===== rtl/acse_top.sv
// register core, receiver and pin control of the serial character engine
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/100ps
module acse_top
  import acse_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // second baud source, an enable pulse on clk
  input  wire logic        alt_clk_tick,
  // serial pins
  input  wire logic        rxd_pin,
  output logic             txd_pin,
  output logic             txd_oe_n,
  // interrupt requests
  output logic             tx_irq,
  output logic             rx_irq
);
  typedef enum logic [3:0] {
    R_HUNT  = 4'b0001,
    R_START = 4'b0010,
    R_DATA  = 4'b0100,
    R_STOP  = 4'b1000
  } acse_rx_st_t;

  typedef struct packed {
    logic [CTRL_W-1:0]     ctrl;
    logic [BAUD_DIV_W-1:0] div;
    logic                  sel;
    logic [8:0]            tbuf;
    logic                  tfull;
    logic [31:0]           rdat;
    logic                  sync1;
    logic                  sync2;
    acse_rx_st_t           rxs;
    logic [4:0]            rt;
    logic [3:0]            bitn;
    logic [2:0]            hist;
    logic [1:0]            smp;
    logic [8:0]            sh;
    logic                  nz;
    logic [7:0]            rx_data;
    logic                  rx_ninth;
    logic                  rxf;
    logic                  ovr;
    logic                  nf;
    logic                  fe;
    logic                  break_flag;
  } acse_core_reg_t;

  // the line idles high, so the synchroniser starts there
  localparam acse_core_reg_t CORE_RST = '{
    ctrl:  CTRL_RST,
    div:   BAUD_DIV_RST,
    rxs:   R_HUNT,
    sync1: 1'b1,
    sync2: 1'b1,
    default: '0
  };

  acse_core_reg_t s_q;
  acse_core_reg_t s_d;
  acse_tx_if      tb();

  logic        setup;
  logic        access;
  logic        mapped;
  logic        wr_data;
  logic        rd_data;
  logic        rd_stat2;
  logic        port_en;
  logic        tx_empty_flag;
  logic        tx_complete_flag;
  logic        tick;
  logic [4:0]  rt_now;
  logic [2:0]  trio;
  logic        vote;
  logic        disagree;
  logic [3:0]  nlast;
  logic [7:0]  data8;
  logic        brk_char;
  logic        rx_done;
  logic [31:0] rd_mux;

  // bus decode; reads are captured in setup so prdata comes from a flop
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = paddr inside {CONTROL_REG_ONE, STATUS_REG_ONE, STATUS_REG_TWO,
                                SERIAL_DATA_REG, BAUD_REG};
  assign wr_data = access && pwrite && (paddr == SERIAL_DATA_REG);
  assign rd_data = access && !pwrite && (paddr == SERIAL_DATA_REG);
  assign rd_stat2 = access && !pwrite && (paddr == STATUS_REG_TWO);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = s_q.rdat;

  assign port_en = s_q.ctrl[PORT_ENABLE_BIT];
  assign tx_empty_flag = !s_q.tfull;
  assign tx_complete_flag = tb.idle && !s_q.tfull && !s_q.ctrl[SEND_BREAK_BIT];

  // transmitter hand-off
  assign tb.char9 = s_q.ctrl[CHAR9_BIT];
  assign tb.tx_en = s_q.ctrl[TX_ENABLE_BIT] && port_en;
  assign tb.brk = s_q.ctrl[SEND_BREAK_BIT] && port_en;
  assign tb.buf_full = s_q.tfull;
  assign tb.buf_data = s_q.tbuf;

  // no encoder here: the shifter output goes straight to the pin
  assign txd_pin = tb.txd;
  assign txd_oe_n = !port_en;

  assign tx_irq = (tx_empty_flag && s_q.ctrl[TX_EMPTY_IRQ_EN_BIT])
               || (tx_complete_flag && s_q.ctrl[TX_COMPLETE_IRQ_EN_BIT]);
  assign rx_irq = s_q.rxf && s_q.ctrl[RX_FULL_IRQ_EN_BIT];

  // receiver sampling helpers
  assign tick = tb.tick16;
  assign rt_now = (s_q.rt == RT_PER_BIT) ? 5'h01 : s_q.rt + 5'h01;
  assign trio = {s_q.smp, s_q.sync2};
  assign vote = (trio[0] && trio[1]) || (trio[0] && trio[2]) || (trio[1] && trio[2]);
  assign disagree = (|trio) && !(&trio);
  assign nlast = s_q.ctrl[CHAR9_BIT] ? 4'h8 : 4'h7;
  assign data8 = s_q.ctrl[CHAR9_BIT] ? s_q.sh[7:0] : s_q.sh[8:1];
  assign brk_char = !vote && (s_q.ctrl[CHAR9_BIT] ? (s_q.sh == 9'h000)
                                                  : (s_q.sh[8:1] == 8'h00));
  assign rx_done = port_en && tick && (s_q.rxs == R_STOP) && (rt_now == RT_DATA_C);

  always_comb begin
    rd_mux = '0;
    case (paddr)
      CONTROL_REG_ONE: begin
        rd_mux[CTRL_W-1:0] = s_q.ctrl;
      end
      STATUS_REG_ONE: begin
        rd_mux[TX_EMPTY_POS] = tx_empty_flag;
        rd_mux[TX_COMPLETE_POS] = tx_complete_flag;
        rd_mux[RX_FULL_POS] = s_q.rxf;
        rd_mux[OVERRUN_POS] = s_q.ovr;
        rd_mux[NOISE_POS] = s_q.nf;
        rd_mux[FRAMING_POS] = s_q.fe;
      end
      STATUS_REG_TWO: begin
        rd_mux[BREAK_POS] = s_q.break_flag;
        rd_mux[RX_PROGRESS_POS] = (s_q.rxs != R_HUNT);
        rd_mux[RX_NINTH_POS] = s_q.rx_ninth;
      end
      SERIAL_DATA_REG: begin
        rd_mux[7:0] = s_q.rx_data;
      end
      BAUD_REG: begin
        rd_mux[BAUD_DIV_W-1:0] = s_q.div;
        rd_mux[BAUD_CLK_SEL_BIT] = s_q.sel;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.sync1 = rxd_pin;
    s_d.sync2 = s_q.sync1;
    if (setup) begin
      s_d.rdat = rd_mux;
    end
    if (access && pwrite && (paddr == CONTROL_REG_ONE)) begin
      s_d.ctrl = pwdata[CTRL_W-1:0];
    end
    if (access && pwrite && (paddr == BAUD_REG)) begin
      s_d.div = pwdata[BAUD_DIV_W-1:0];
      s_d.sel = pwdata[BAUD_CLK_SEL_BIT];
    end
    // ninth transmit bit is taken with the byte it belongs to
    if (wr_data) begin
      s_d.tbuf = {s_q.ctrl[TX_NINTH_BIT_POS], pwdata[7:0]};
    end
    s_d.tfull = wr_data || (s_q.tfull && !tb.take);
    // clears first, so a flag raised in the same cycle survives
    if (rd_data) begin
      s_d.rxf = 1'b0;
      s_d.ovr = 1'b0;
      s_d.nf = 1'b0;
      s_d.fe = 1'b0;
    end
    if (rd_stat2) begin
      s_d.break_flag = 1'b0;
    end
    if (!port_en) begin
      s_d.rxs = R_HUNT;
      s_d.hist = '0;
    end else if (tick) begin
      s_d.rt = rt_now;
      unique case (s_q.rxs)
        R_HUNT: begin
          s_d.hist = {s_q.hist[1:0], s_q.sync2};
          // a fall after three ones is sample one of a start bit
          if (s_q.hist == 3'b111 && !s_q.sync2) begin
            s_d.rxs = R_START;
            s_d.rt = 5'h01;
            s_d.sh = '0;
            s_d.nz = 1'b0;
          end
        end
        R_START: begin
          if (rt_now == RT_START_A || rt_now == RT_START_B) begin
            s_d.smp = {s_q.smp[0], s_q.sync2};
          end
          if (rt_now == RT_START_C) begin
            s_d.nz = disagree;
            if (vote) begin
              s_d.rxs = R_HUNT;
              s_d.hist = '0;
            end
          end
          if (rt_now == RT_PER_BIT) begin
            s_d.rxs = R_DATA;
            s_d.bitn = '0;
          end
        end
        R_DATA: begin
          if (rt_now == RT_DATA_A || rt_now == RT_DATA_B) begin
            s_d.smp = {s_q.smp[0], s_q.sync2};
          end
          if (rt_now == RT_DATA_C) begin
            s_d.sh = {vote, s_q.sh[8:1]};
            s_d.nz = s_q.nz || disagree;
          end
          if (rt_now == RT_PER_BIT) begin
            s_d.bitn = s_q.bitn + 4'h1;
            if (s_q.bitn == nlast) begin
              s_d.rxs = R_STOP;
            end
          end
        end
        R_STOP: begin
          if (rt_now == RT_DATA_A || rt_now == RT_DATA_B) begin
            s_d.smp = {s_q.smp[0], s_q.sync2};
          end
          if (rt_now == RT_DATA_C) begin
            s_d.rxs = R_HUNT;
            s_d.hist = '0;
            // unread data is kept; the newer character is dropped
            if (s_d.rxf) begin
              s_d.ovr = 1'b1;
            end else begin
              s_d.rx_data = brk_char ? 8'h00 : data8;
              s_d.rx_ninth = brk_char ? 1'b0 : s_q.sh[8];
            end
            s_d.rxf = 1'b1;
            s_d.fe = s_d.fe || !vote;
            s_d.nf = s_d.nf || s_q.nz || disagree;
            if (brk_char) begin
              s_d.break_flag = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= CORE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  acse_baud u_baud (
    .clk      (clk),
    .rst      (rst),
    .alt_tick (alt_clk_tick),
    .clk_sel  (s_q.sel),
    .div      (s_q.div),
    .tb       (tb.baud)
  );

  acse_tx u_tx (
    .clk (clk),
    .rst (rst),
    .tb  (tb.xmit)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_release;
    !port_en |=> s_q.rxs == R_HUNT && s_q.hist == 3'b000;
  endproperty
  a_release: assert property (p_release)
    else $error("receiver active while the port is disabled");

  property p_fe_with_full;
    $rose(s_q.fe) |-> s_q.rxf && $past(rx_done);
  endproperty
  a_fe_with_full: assert property (p_fe_with_full)
    else $error("framing error raised apart from receive full");

  property p_break_effects;
    $rose(s_q.break_flag) |-> s_q.fe && s_q.rxf && (s_q.ovr || (s_q.rx_data == 8'h00 && !s_q.rx_ninth));
  endproperty
  a_break_effects: assert property (p_break_effects)
    else $error("break left data or flags wrong");

  property p_break_seen;
    rx_done && brk_char |=> s_q.break_flag;
  endproperty
  a_break_seen: assert property (p_break_seen)
    else $error("break character not flagged");

  property p_full_irq;
    rx_done |=> s_q.rxf && (rx_irq == s_q.ctrl[RX_FULL_IRQ_EN_BIT]);
  endproperty
  a_full_irq: assert property (p_full_irq)
    else $error("receive full or its request missing");

  property p_start_reject;
    port_en && tick && s_q.rxs == R_START && rt_now == RT_START_C && vote |=> s_q.rxs == R_HUNT;
  endproperty
  a_start_reject: assert property (p_start_reject)
    else $error("false start bit accepted");

  property p_data_noise;
    port_en && tick && s_q.rxs == R_DATA && rt_now == RT_DATA_C && disagree |=> s_q.nz;
  endproperty
  a_data_noise: assert property (p_data_noise)
    else $error("sample disagreement not noted as noise");

  property p_empty_on_take;
    tb.take && !wr_data |=> tx_empty_flag;
  endproperty
  a_empty_on_take: assert property (p_empty_on_take)
    else $error("transmit empty not set after buffer move");

  property p_ninth_copy;
    rx_done && !s_q.rxf && !rd_data && !s_q.ctrl[CHAR9_BIT] |=> s_q.rx_ninth == s_q.rx_data[7];
  endproperty
  a_ninth_copy: assert property (p_ninth_copy)
    else $error("eight-bit ninth bit is not a copy of bit 7");
endmodule

// ===== inc/acse_pkg.sv
// shared offsets, field positions, reset values and sample positions
package acse_pkg;
  // register byte offsets
  localparam logic [7:0] CONTROL_REG_ONE = 8'h00;
  localparam logic [7:0] STATUS_REG_ONE  = 8'h04;
  localparam logic [7:0] STATUS_REG_TWO  = 8'h08;
  localparam logic [7:0] SERIAL_DATA_REG = 8'h0c;
  localparam logic [7:0] BAUD_REG        = 8'h10;
  // control_reg_one fields
  localparam int CTRL_W                 = 8;
  localparam int PORT_ENABLE_BIT        = 0;
  localparam int CHAR9_BIT              = 1;
  localparam int TX_ENABLE_BIT          = 2;
  localparam int SEND_BREAK_BIT         = 3;
  localparam int TX_EMPTY_IRQ_EN_BIT    = 4;
  localparam int TX_COMPLETE_IRQ_EN_BIT = 5;
  localparam int RX_FULL_IRQ_EN_BIT     = 6;
  localparam int TX_NINTH_BIT_POS       = 7;
  localparam logic [7:0] CTRL_RST       = 8'h00;
  // status_reg_one fields
  localparam int TX_EMPTY_POS     = 0;
  localparam int TX_COMPLETE_POS  = 1;
  localparam int RX_FULL_POS      = 2;
  localparam int OVERRUN_POS      = 3;
  localparam int NOISE_POS        = 4;
  localparam int FRAMING_POS      = 5;
  // status_reg_two fields
  localparam int BREAK_POS        = 0;
  localparam int RX_PROGRESS_POS  = 1;
  localparam int RX_NINTH_POS     = 2;
  // baud register
  localparam int BAUD_DIV_W        = 16;
  localparam int BAUD_CLK_SEL_BIT  = 16;
  localparam logic [15:0] BAUD_DIV_RST = 16'h0000;
  // sample tick positions inside one bit
  localparam logic [4:0] RT_PER_BIT = 5'h10;
  localparam logic [4:0] RT_START_A = 5'h03;
  localparam logic [4:0] RT_START_B = 5'h05;
  localparam logic [4:0] RT_START_C = 5'h07;
  localparam logic [4:0] RT_DATA_A  = 5'h08;
  localparam logic [4:0] RT_DATA_B  = 5'h09;
  localparam logic [4:0] RT_DATA_C  = 5'h0a;
  localparam logic [3:0] TX_RT_LAST = 4'hf;
endpackage

// ===== inc/acse_tx_if.sv
// baud tick and transmit hand-off between the core and its helpers
`timescale 1ns/100ps
interface acse_tx_if;
  logic       tick16;
  logic       char9;
  logic       tx_en;
  logic       brk;
  logic       buf_full;
  logic [8:0] buf_data;
  logic       take;
  logic       idle;
  logic       txd;
  modport core (output char9, tx_en, brk, buf_full, buf_data,
                input tick16, take, idle, txd);
  modport xmit (input tick16, char9, tx_en, brk, buf_full, buf_data,
                output take, idle, txd);
  modport baud (output tick16);
endinterface

// ===== rtl/acse_baud.sv
// baud tick divider with a selectable source
`timescale 1ns/100ps
module acse_baud
  import acse_pkg::*;
#(
  parameter int DIV_W = BAUD_DIV_W
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // source and divisor
  input  wire logic             alt_tick,
  input  wire logic             clk_sel,
  input  wire logic [DIV_W-1:0] div,
  // 16x sample tick
  acse_tx_if.baud               tb
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } acse_baud_reg_t;

  acse_baud_reg_t s_q;
  acse_baud_reg_t s_d;
  logic           src;

  if (DIV_W < 1 || DIV_W > 32) begin
    $error("acse_baud: divisor width out of range");
  end

  assign src = clk_sel ? alt_tick : 1'b1;
  assign tb.tick16 = s_q.tick;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (src) begin
      if (s_q.cnt >= div) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  property p_no_src_no_tick;
    @(posedge clk) disable iff (rst) !src |=> !tb.tick16;
  endproperty
  a_no_src_no_tick: assert property (p_no_src_no_tick)
    else $error("baud tick without a source event");
endmodule

// ===== rtl/acse_tx.sv
// transmit shifter: preamble, data frames, break and idle characters
`timescale 1ns/100ps
module acse_tx
  import acse_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // core side
  acse_tx_if.xmit   tb
);
  typedef enum logic [3:0] {
    T_IDLE  = 4'b0001,
    T_FRAME = 4'b0010,
    T_BREAK = 4'b0100,
    T_MARK  = 4'b1000
  } acse_tx_st_t;

  typedef struct packed {
    acse_tx_st_t st;
    logic [10:0] sr;
    logic [3:0]  nbit;
    logic [3:0]  rt;
    logic        pend;
    logic        en_q;
    logic        txd;
  } acse_tx_reg_t;

  localparam acse_tx_reg_t TX_RST = '{st: T_IDLE, txd: 1'b1, default: '0};

  acse_tx_reg_t s_q;
  acse_tx_reg_t s_d;
  logic [3:0]   nlast;
  logic         take;

  assign nlast = tb.char9 ? 4'ha : 4'h9;
  assign tb.take = take;
  assign tb.idle = (s_q.st == T_IDLE) && !s_q.pend;
  assign tb.txd = s_q.txd;

  always_comb begin
    s_d = s_q;
    take = 1'b0;
    s_d.en_q = tb.tx_en;
    // an enable edge owes one idle character, also mid-character
    if (tb.tx_en && !s_q.en_q) begin
      s_d.pend = 1'b1;
    end
    unique case (s_q.st)
      T_IDLE: begin
        s_d.rt = '0;
        s_d.nbit = '0;
        if (tb.tx_en && tb.brk) begin
          s_d.st = T_BREAK;
          s_d.sr = '0;
        end else if (tb.tx_en && s_d.pend) begin
          s_d.st = T_MARK;
          s_d.sr = '1;
          s_d.pend = 1'b0;
        end else if (tb.tx_en && tb.buf_full) begin
          s_d.st = T_FRAME;
          s_d.sr = tb.char9 ? {1'b1, tb.buf_data, 1'b0}
                            : {2'b11, tb.buf_data[7:0], 1'b0};
          take = 1'b1;
        end
      end
      T_FRAME, T_BREAK, T_MARK: begin
        if (tb.tick16) begin
          s_d.rt = s_q.rt + 4'h1;
          if (s_q.rt == TX_RT_LAST) begin
            s_d.sr = {s_q.st != T_BREAK, s_q.sr[10:1]};
            s_d.nbit = s_q.nbit + 4'h1;
            if (s_q.nbit == nlast) begin
              s_d.nbit = '0;
              // a held break runs on with no idle cycle between characters
              if (s_q.st == T_BREAK && tb.brk && tb.tx_en) begin
                s_d.st = T_BREAK;
              end else begin
                s_d.st = T_IDLE;
                if (s_q.st == T_BREAK && !tb.brk) begin
                  s_d.pend = 1'b1;
                end
              end
            end
          end
        end
      end
    endcase
    s_d.txd = (s_d.st == T_IDLE) ? 1'b1 : s_d.sr[0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= TX_RST;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rise_idle;
    s_q.st == T_IDLE && !tb.brk && tb.tx_en && !s_q.en_q;
  endsequence
  sequence s_break_last;
    s_q.st == T_BREAK && tb.tick16 && s_q.rt == TX_RT_LAST && s_q.nbit == nlast && !tb.brk;
  endsequence

  property p_preamble;
    s_rise_idle |=> s_q.st == T_MARK && tb.txd && !take;
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("no preamble after transmitter enable");

  property p_start_bit;
    take |=> !tb.txd && s_q.st == T_FRAME;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("frame did not open with a zero start bit");

  property p_mark_after_break;
    s_break_last |=> tb.txd ##1 tb.txd;
  endproperty
  a_mark_after_break: assert property (p_mark_after_break)
    else $error("break not followed by a mark");
endmodule

// ===== dv/acse_remote.sv
// remote serial sender on the receive pin, sixteen clocks a bit
`timescale 1ns/100ps
module acse_remote (
  // clock
  input  wire logic clk,
  // line
  output logic      rxd
);
  initial rxd = 1'b1;
  // caller packs start, data lsb first, stop; first bit goes out first
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) rxd <= bits[i];
      repeat (15) @(posedge clk);
    end
    @(posedge clk) rxd <= 1'b1;
  endtask
endmodule

// ===== dv/tb_acse_top.sv
// testbench: registers, transmit framing, receive and break handling
`timescale 1ns/100ps
module tb_acse_top;
  import acse_pkg::*;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        alt_clk_tick;
  logic        rxd_pin;
  logic        txd_pin;
  logic        txd_oe_n;
  logic        tx_irq;
  logic        rx_irq;
  int          error_cnt;
  int          samples_checked;

  acse_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alt_clk_tick(alt_clk_tick), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
    .txd_oe_n(txd_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq));
  acse_remote remote (.clk(clk), .rxd(rxd_pin));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic to_fail(input string what);
    error_cnt++;
    $display("unexpected wait on %s: expected done seen none", what);
    results;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) to_fail("pready");
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // reading the pin right after an edge sees the settled pre-edge value
  task automatic wait_txd(input logic lvl, input int lim, output int n);
    n = 0;
    while (txd_pin !== lvl) begin
      @(posedge clk);
      n++;
      if (n > lim) to_fail("txd");
    end
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    rd(CONTROL_REG_ONE, r);
    chk("ctrl reset", {24'h0, CTRL_RST}, r);
    rd(BAUD_REG, r);
    chk("baud reset", {16'h0, BAUD_DIV_RST}, r);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    chk("txd reset", 32'h1, {31'h0, txd_pin});
    chk("oe reset", 32'h1, {31'h0, txd_oe_n});
    // alt tick runs every cycle, so the second source keeps the bit time
    wr(BAUD_REG, 32'h0001_0000);
    // a silent second source must stall the sample tick
    alt_clk_tick <= 1'b0;
    repeat (4) @(posedge clk);
    alt_clk_tick <= 1'b1;
    rd(BAUD_REG, r);
    chk("baud select", 32'h0001_0000, r);
  endtask

  task automatic t_tx(input logic m, input logic [8:0] d);
    logic [31:0] c;
    logic [31:0] r;
    logic [10:0] got;
    logic [10:0] exp;
    int          n;
    c = {24'h0, d[8], 2'b00, 1'b1, 2'b00, m, 1'b1};
    exp = m ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
    got = 11'h7ff;
    wr(CONTROL_REG_ONE, c);
    wr(CONTROL_REG_ONE, c | 32'h4);
    rd(STATUS_REG_ONE, r);
    wr(SERIAL_DATA_REG, {23'h0, d});
    rd(STATUS_REG_ONE, r);
    chk("tx empty queued", 32'h0, r & 32'h1);
    wait_txd(1'b0, 600, n);
    chk("preamble", 32'h1, 32'(n >= 150 + 16 * m));
    repeat (8) @(posedge clk);
    for (int i = 0; i < 10 + m; i++) begin
      got[i] = txd_pin;
      repeat (16) @(posedge clk);
    end
    chk("tx frame", {21'h0, exp}, {21'h0, got});
    chk("tx empty irq", 32'h1, {31'h0, tx_irq});
    rd(STATUS_REG_ONE, r);
    chk("tx complete", 32'h3, r & 32'h3);
    chk("txd idle", 32'h1, {31'h0, txd_pin});
  endtask

  // toggle the enable during a frame and re-enable before its stop bit
  task automatic t_idleq;
    int n;
    wr(SERIAL_DATA_REG, 32'h0ff);
    wait_txd(1'b0, 600, n);
    wr(CONTROL_REG_ONE, 32'ha3);
    wr(CONTROL_REG_ONE, 32'ha7);
    wr(SERIAL_DATA_REG, 32'h0ff);
    wait_txd(1'b1, 600, n);
    wait_txd(1'b0, 600, n);
    chk("queued idle", 32'h1, 32'(n >= 16 * 21));
    chk("busy tx irq", 32'h0, {31'h0, tx_irq});
    repeat (180) @(posedge clk);
    chk("complete tx irq", 32'h1, {31'h0, tx_irq});
  endtask

  task automatic t_rx(input logic m, input logic brk, input logic [8:0] d);
    logic [31:0] r;
    logic        nb;
    int          n;
    nb = brk ? 1'b0 : (m ? d[8] : d[7]);
    wr(CONTROL_REG_ONE, {25'h0, 1'b1, 4'h0, m, 1'b1});
    remote.send(brk ? 11'h0 : (m ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0}), 10 + m);
    n = 0;
    while (rx_irq !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 40) to_fail("rx irq");
    end
    rd(STATUS_REG_ONE, r);
    chk("rx status", {26'h0, brk, 5'h4}, r & 32'h24);
    rd(STATUS_REG_TWO, r);
    chk("rx ninth, break", {29'h0, nb, 1'b0, brk}, r & 32'h5);
    rd(SERIAL_DATA_REG, r);
    chk("rx data", {24'h0, d[7:0]}, r);
    @(posedge clk);
    chk("rx irq cleared", 32'h0, {31'h0, rx_irq});
  endtask

  task automatic t_brk;
    int n;
    wr(CONTROL_REG_ONE, 32'hd);
    wait_txd(1'b0, 600, n);
    n = 0;
    repeat (200) begin
      @(posedge clk);
      n += (txd_pin !== 1'b0);
    end
    chk("break low", 32'h0, n);
    chk("pin driven", 32'h0, {31'h0, txd_oe_n});
    wr(CONTROL_REG_ONE, 32'h5);
    wait_txd(1'b1, 400, n);
    n = 0;
    repeat (16) begin
      @(posedge clk);
      n += (txd_pin !== 1'b1);
    end
    chk("ones after break", 32'h0, n);
    wr(CONTROL_REG_ONE, 32'h0);
    @(posedge clk);
    chk("pin released", 32'h1, {31'h0, txd_oe_n});
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    alt_clk_tick = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_tx(1'b0, 9'h0a5);
    t_tx(1'b1, 9'h13c);
    t_idleq;
    t_rx(1'b0, 1'b0, 9'h080);
    t_rx(1'b1, 1'b0, 9'h13c);
    t_rx(1'b0, 1'b1, 9'h000);
    t_brk;
    results;
  end
endmodule
